// ===== hdl/gsb_bridge.sv
`include "gsb_defs.svh"

module gsb_bridge (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_link_clk,
  input  wire logic       i_rs232_mode,
  input  wire logic       i_uart_txd,
  output logic            o_uart_rxd,
  output logic            o_uart_clk,
  output logic            o_uart_dtr,
  input  wire logic       i_rs_rxd,
  input  wire logic       i_rs_dtr,
  output logic            o_rs_txd,
  input  wire logic [7:0] i_gpib_data,
  output logic      [7:0] o_gpib_data,
  output logic            o_gpib_dir,
  output logic      [5:0] o_gpib_ctrl,
  output logic            o_gpib_write,
  output logic            o_parallel_load_select,
  output logic            o_start_detect
);

  // ----------------------------------------------------------------
  // pin synchronisers into the link domain
  // ----------------------------------------------------------------
  gsb_pkg::gsb_pin_type pin_s;
  gsb_pkg::gsb_pin_type pin_raw;
  logic                 tgl_s;

  assign pin_raw = '{rs232_mode: i_rs232_mode, rxd: i_uart_txd, gpib_in: i_gpib_data};

  // line idles high, so the rxd stage resets high to avoid a false start
  gsb_sync #(.W(10)) u_link_sync (
    .i_clk     (i_link_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (pin_raw),
    .i_rst_val (10'h100),
    .o_sync    (pin_s)
  );

  gsb_pkg::gsb_link_type l_ff;
  gsb_pkg::gsb_link_type nxt_l;
  gsb_pkg::gsb_core_type c_ff;
  gsb_pkg::gsb_core_type nxt_c;

  // frame-done toggle crosses to the core clock
  gsb_sync #(.W(1)) u_core_sync (
    .i_clk     (i_core_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (l_ff.frame_tgl),
    .i_rst_val (1'b0),
    .o_sync    (tgl_s)
  );

  // ----------------------------------------------------------------
  // link sequencer: start, one-bit delay, eight shifts, stop
  // ----------------------------------------------------------------
  always_comb begin
    nxt_l = l_ff;
    unique case (l_ff.phase)
      gsb_pkg::GSB_IDLE: begin
        nxt_l.tx  = `GSB_LINE_IDLE; // stop bit, then idle
        nxt_l.cnt = '0;
        if (!pin_s.rxd) begin
          nxt_l.phase = gsb_pkg::GSB_DELAY;
          nxt_l.tx    = 1'b0;
        end
      end
      gsb_pkg::GSB_DELAY: begin
        // delayed clock: select has been stable since the last frame
        nxt_l.phase = gsb_pkg::GSB_SHIFT;
        if (l_ff.pls) begin
          nxt_l.data = pin_s.gpib_in;
          nxt_l.pls  = 1'b0;
        end
        // bit 0 already stands behind the two sync flops, so this edge is
        // the first shift; one more wait would take in the stop bit
        nxt_l.tx   = nxt_l.data[0];
        nxt_l.cmd  = {pin_s.rxd, l_ff.cmd[7:1]};
        nxt_l.data = {l_ff.cmd[0], nxt_l.data[7:1]};
      end
      gsb_pkg::GSB_SHIFT: begin
        // cascade: serial in to command, command out to data
        nxt_l.cnt = 3'(l_ff.cnt + 3'h1);
        if (l_ff.cnt == 3'(`GSB_SHIFT_COUNT - 1)) begin
          nxt_l.phase     = gsb_pkg::GSB_IDLE;
          nxt_l.tx        = `GSB_LINE_IDLE;
          nxt_l.pls       = l_ff.cmd[`GSB_CMD_STB_BIT];
          nxt_l.frame_tgl = ~l_ff.frame_tgl;
        end else begin
          nxt_l.cmd  = {pin_s.rxd, l_ff.cmd[7:1]};
          nxt_l.data = {l_ff.cmd[0], l_ff.data[7:1]};
          nxt_l.tx   = l_ff.data[0];
        end
      end
      default: begin
        nxt_l.phase = gsb_pkg::GSB_IDLE;
      end
    endcase
    // serial traffic bypasses the bridge, so hold it parked
    if (pin_s.rs232_mode) begin
      nxt_l.phase = gsb_pkg::GSB_IDLE;
      nxt_l.tx    = `GSB_LINE_IDLE;
      nxt_l.cnt   = '0;
    end
  end

  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      l_ff <= '{phase: gsb_pkg::GSB_IDLE, cnt: 3'h0, cmd: `GSB_CMD_RST,
                data: `GSB_DATA_RST, tx: `GSB_LINE_IDLE, pls: 1'b0, frame_tgl: 1'b0};
    end else begin
      l_ff <= nxt_l;
    end
  end

  // ----------------------------------------------------------------
  // core side: take command and data when a frame completes
  // ----------------------------------------------------------------
  // cmd and data hold for at least two link clocks after the toggle,
  // longer than the three core edges the crossing needs
  always_comb begin
    nxt_c       = c_ff;
    nxt_c.write = 1'b0;
    if (tgl_s != c_ff.seen_tgl) begin
      nxt_c.seen_tgl  = tgl_s;
      nxt_c.gpib_data = l_ff.data;
      nxt_c.dir       = l_ff.cmd[`GSB_CMD_DIR_BIT];
      nxt_c.ctrl      = l_ff.cmd[`GSB_CMD_CTRL_MSB:`GSB_CMD_CTRL_LSB];
      nxt_c.write     = ~l_ff.cmd[`GSB_CMD_DIR_BIT];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      c_ff <= '{gpib_data: `GSB_DATA_RST, ctrl: 6'h00, dir: 1'b0, write: 1'b0,
                seen_tgl: 1'b0};
    end else begin
      c_ff <= nxt_c;
    end
  end

  // ----------------------------------------------------------------
  // outputs and the RS232 bypass path
  // ----------------------------------------------------------------
  // link clock leaves with the data so the UART samples 1x
  assign o_uart_clk             = i_link_clk;
  // bypass is a plain wire path; only the select is synchronised
  assign o_uart_rxd             = pin_s.rs232_mode ? i_rs_rxd : l_ff.tx;
  assign o_rs_txd               = pin_s.rs232_mode ? i_uart_txd : `GSB_LINE_IDLE;
  assign o_uart_dtr             = pin_s.rs232_mode ? i_rs_dtr : 1'b0;
  assign o_start_detect         = (l_ff.phase != gsb_pkg::GSB_IDLE);
  assign o_parallel_load_select = l_ff.pls;
  assign o_gpib_data            = c_ff.gpib_data;
  assign o_gpib_dir             = c_ff.dir;
  assign o_gpib_ctrl            = c_ff.ctrl;
  assign o_gpib_write           = c_ff.write;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_start_bit;
    @(posedge i_link_clk) disable iff (!i_rst_n)
    (l_ff.phase == gsb_pkg::GSB_IDLE && !pin_s.rxd && !pin_s.rs232_mode)
      |=> (l_ff.tx == 1'b0 && o_start_detect);
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("start bit not sent after start detect");

  property p_one_bit_delay;
    @(posedge i_link_clk) disable iff (!i_rst_n)
    (l_ff.phase == gsb_pkg::GSB_DELAY && !pin_s.rs232_mode)
      |=> (l_ff.phase == gsb_pkg::GSB_SHIFT && l_ff.cnt == 3'h0);
  endproperty
  a_one_bit_delay: assert property (p_one_bit_delay)
    else $error("shifting did not start one bit after start");

  property p_eight_shifts;
    @(posedge i_link_clk) disable iff (!i_rst_n || pin_s.rs232_mode)
    $rose(l_ff.phase == gsb_pkg::GSB_SHIFT)
      |-> (l_ff.phase == gsb_pkg::GSB_SHIFT)[*8]
      ##1 (l_ff.phase == gsb_pkg::GSB_IDLE && l_ff.tx == 1'b1 && !o_start_detect);
  endproperty
  a_eight_shifts: assert property (p_eight_shifts)
    else $error("frame did not end after eight shifts with a stop bit");

  property p_cascade;
    @(posedge i_link_clk) disable iff (!i_rst_n)
    ((l_ff.phase == gsb_pkg::GSB_DELAY
      || (l_ff.phase == gsb_pkg::GSB_SHIFT && l_ff.cnt != 3'(`GSB_SHIFT_COUNT - 1)))
     && !pin_s.rs232_mode)
      |=> (l_ff.cmd[7] == $past(pin_s.rxd) && l_ff.data[7] == $past(l_ff.cmd[0]));
  endproperty
  a_cascade: assert property (p_cascade)
    else $error("serial bit did not cascade through command into data");

  property p_core_take;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (tgl_s != c_ff.seen_tgl)
      |=> (o_gpib_dir == $past(l_ff.cmd[0]) && o_gpib_data == $past(l_ff.data)
           && o_gpib_write == !o_gpib_dir);
  endproperty
  a_core_take: assert property (p_core_take)
    else $error("gpib outputs did not follow the finished frame");

  property p_capture;
    @(posedge i_link_clk) disable iff (!i_rst_n)
    (l_ff.phase == gsb_pkg::GSB_DELAY && l_ff.pls && !pin_s.rs232_mode)
      |=> (l_ff.data[6:0] == $past(pin_s.gpib_in[7:1]) && l_ff.tx == $past(pin_s.gpib_in[0])
           && !o_parallel_load_select);
  endproperty
  a_capture: assert property (p_capture)
    else $error("controller byte not captured under load select");

  property p_select_stable;
    @(posedge i_link_clk) disable iff (!i_rst_n)
    (l_ff.phase == gsb_pkg::GSB_DELAY && l_ff.pls) |-> $past(l_ff.pls);
  endproperty
  a_select_stable: assert property (p_select_stable)
    else $error("load select not stable before capture edge");

  property p_bypass;
    @(posedge i_link_clk) disable iff (!i_rst_n)
    pin_s.rs232_mode |=> (l_ff.phase == gsb_pkg::GSB_IDLE && l_ff.tx == 1'b1);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bridge active during rs232 mode");

endmodule

// ===== hdl/gsb_defs.svh
`ifndef GSB_DEFS_SVH
`define GSB_DEFS_SVH

// ----------------------------------------------------------------
// serial link timing
// ----------------------------------------------------------------
`define GSB_LINK_RATE_KBAUD 1250
`define GSB_CORE_RATE_MHZ   100
// one link clock per bit in 1x mode
`define GSB_BIT_CLKS        1
// bit period in ns and in core cycles, rounded down, with no lower bound
`define GSB_BIT_NS          800
`define GSB_BIT_CORE_CLKS   ((`GSB_BIT_NS * `GSB_CORE_RATE_MHZ) / 1000)
`define GSB_SHIFT_COUNT     8

// ----------------------------------------------------------------
// command register fields
// ----------------------------------------------------------------
`define GSB_CMD_DIR_BIT     0
`define GSB_CMD_STB_BIT     1
`define GSB_CMD_CTRL_LSB    2
`define GSB_CMD_CTRL_MSB    7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define GSB_CMD_RST         8'h00
`define GSB_DATA_RST        8'h00
`define GSB_LINE_IDLE       1'b1

`endif

// ===== hdl/gsb_pkg.sv
package gsb_pkg;

  // ----------------------------------------------------------------
  // link sequencer phases, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    GSB_IDLE  = 3'b001,
    GSB_DELAY = 3'b010,
    GSB_SHIFT = 3'b100
  } gsb_phase_type;

  // ----------------------------------------------------------------
  // state of the link clock domain
  // ----------------------------------------------------------------
  typedef struct packed {
    gsb_phase_type phase;
    logic [2:0]    cnt;
    logic [7:0]    cmd;
    logic [7:0]    data;
    logic          tx;
    logic          pls;
    logic          frame_tgl;
  } gsb_link_type;

  // ----------------------------------------------------------------
  // state of the core clock domain
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] gpib_data;
    logic [5:0] ctrl;
    logic       dir;
    logic       write;
    logic       seen_tgl;
  } gsb_core_type;

  // ----------------------------------------------------------------
  // pins sampled into the link domain
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       rs232_mode;
    logic       rxd;
    logic [7:0] gpib_in;
  } gsb_pin_type;

endpackage

// ===== hdl/gsb_sync.sv
module gsb_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  input  wire logic [W-1:0] i_rst_val,
  output logic      [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } gsb_sync_state_type;

  gsb_sync_state_type state_ff;
  gsb_sync_state_type nxt_state;

  // ----------------------------------------------------------------
  // two-stage synchroniser; first stage feeds only the second
  // ----------------------------------------------------------------
  // stages hold the input xor the reset value, so a plain zero reset
  // shows the reset value while data still passes through unchanged
  always_comb begin
    nxt_state      = state_ff;
    nxt_state.meta = i_async ^ i_rst_val;
    nxt_state.sync = state_ff.meta;
  end

  // reset value is a constant tied at the instance
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_sync = state_ff.sync ^ i_rst_val;

endmodule

// ===== verif/gsb_uart_model.sv
// ----------------------------------------
// processor uart across the isolated link
// ----------------------------------------
module gsb_uart_model (
  input  wire logic       i_link_clk,
  input  wire logic       i_rxd,
  output logic            o_txd,
  output logic            o_got,
  output logic      [8:0] o_got_frame
);
  timeunit 1ns;
  timeprecision 1ps;

  // one bit per link clock, moved off the sampling edge
  task automatic send(input logic [7:0] v, input int gap);
    @(negedge i_link_clk) o_txd = 1'b0;
    for (int i = 0; i < 8; i++) @(negedge i_link_clk) o_txd = v[i];
    @(negedge i_link_clk) o_txd = 1'b1;
    repeat (gap) @(negedge i_link_clk);
  endtask

  // hunt a start bit, then take eight bits and the stop
  initial begin
    o_txd = 1'b1;
    o_got = 1'b0;
    o_got_frame = '0;
    forever begin
      @(negedge i_link_clk) o_got = 1'b0;
      if (i_rxd === 1'b0) begin
        for (int i = 0; i < 9; i++) @(negedge i_link_clk) o_got_frame[i] = i_rxd;
        o_got = 1'b1;
      end
    end
  end
endmodule

// ===== verif/gsb_bridge_bench.sv
module gsb_bridge_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, lclk, rst_n, mode, txd, rrxd, rdtr, byp;
  logic        urxd, uclk, udtr, rtxd, dir, wr, pls, sd, got;
  logic [7:0]  gin, gout, p1, p2, e;
  logic [5:0]  ctrl;
  logic [8:0]  frm;
  logic [7:0]  rq[$];
  logic [13:0] wq[$];
  logic [7:0]  pat[4] = '{8'h02, 8'hFF, 8'h00, 8'h03};
  int          seed = 32'h6DE89700;
  int          fails = 0;
  int          checked = 0;

  // link clock offset so its edges never meet the core edges
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #3;
    forever #15 lclk = ~lclk;
  end

  gsb_bridge uut (
    .i_core_clk(clk),
    .i_rst_n(rst_n),
    .i_link_clk(lclk),
    .i_rs232_mode(mode),
    .i_uart_txd(txd),
    .o_uart_rxd(urxd),
    .o_uart_clk(uclk),
    .o_uart_dtr(udtr),
    .i_rs_rxd(rrxd),
    .i_rs_dtr(rdtr),
    .o_rs_txd(rtxd),
    .i_gpib_data(gin),
    .o_gpib_data(gout),
    .o_gpib_dir(dir),
    .o_gpib_ctrl(ctrl),
    .o_gpib_write(wr),
    .o_parallel_load_select(pls),
    .o_start_detect(sd)
  );

  gsb_uart_model mdl (
    .i_link_clk(lclk),
    .i_rxd(urxd),
    .o_txd(txd),
    .o_got(got),
    .o_got_frame(frm)
  );

  task automatic chk(input string n, input logic [13:0] s, input logic [13:0] x);
    checked++;
    if (s !== x) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask

  task automatic report_and_stop();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // monitors: oldest note against each result
  // ----------------------------------------
  always @(posedge got) begin
    if (!byp) begin
      e = (rq.size() > 0) ? rq.pop_front() : ~frm[7:0];
      chk("return byte", frm[7:0], e);
      chk("stop bit", frm[8], 1'b1);
    end
  end
  // write pulse lands on a rising edge, so look mid-cycle
  always @(negedge clk) begin
    if (wr === 1'b1) begin
      if (wq.size() == 0) chk("spurious write", 14'h1, 14'h0);
      else chk("gpib write", {gout, ctrl}, wq.pop_front());
    end
  end

  // byte returns the capture if the last command asked for it
  task automatic frame(input logic [7:0] v, input int gap);
    @(negedge clk) gin = 8'($random(seed));
    rq.push_back(p1[1] ? gin : p2);
    if (v[0] == 1'b0) wq.push_back({p1, v[7:2]});
    p2 = p1;
    p1 = v;
    fork
      mdl.send(v, gap);
      begin
        repeat (5) @(negedge lclk);
        chk("start flag", sd, 1'b1);
      end
    join
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    mode = 1'b0;
    rrxd = 1'b1;
    rdtr = 1'b0;
    byp = 1'b0;
    gin = 8'h00;
    p1 = 8'h00;
    p2 = 8'h00;
    repeat (10) @(negedge clk);
    chk("reset rxd", urxd, 1'b1);
    chk("reset gpib", {gout, ctrl}, 14'h0);
    chk("reset flags", {dir, wr, pls, sd}, 4'h0);
    chk("idle bypass", {udtr, rtxd}, 2'b01);
    rst_n = 1'b1;
    repeat (4) @(negedge lclk);
    // fixed corners back to back, then random bytes with gaps cycling 0 to 3 bits
    foreach (pat[i]) frame(pat[i], 0);
    for (int i = 0; i < 14; i++) frame(8'($random(seed)), i % 4);
    for (int k = 0; k < 300 && rq.size() + wq.size() > 0; k++) @(negedge clk);
    chk("drained", 14'(rq.size() + wq.size()), 14'h0);
    repeat (20) @(negedge clk);
    chk("dir ctrl", {dir, ctrl}, {p1[0], p1[7:2]});
    chk("load select", pls, p1[1]);
    // bypass: a frame sent now must not start the sequencer
    mode = 1'b1;
    byp = 1'b1;
    repeat (4) @(negedge lclk);
    fork
      mdl.send(8'hA5, 1);
      for (int k = 0; k < 60; k++) begin
        @(negedge clk) {rrxd, rdtr} = 2'($random(seed));
        #1;
        chk("bypass", {urxd, udtr, rtxd}, {rrxd, rdtr, txd});
        chk("no start", sd, 1'b0);
        chk("data clock", uclk, lclk);
      end
    join
    report_and_stop();
  end
endmodule
